/* File: core/vr_supervisor_phase_control.sv */
// Supervisory, phase-shedding and crowbar logic with an AHB-Lite register port
`timescale 1ns/1ns
`default_nettype none
module vr_supervisor_phase_control
#(
   parameter int BLANK_CYC   = vr_supervisor_pkg::BLANK_CYC,
   parameter int TURN_ON_CYC = vr_supervisor_pkg::TURN_ON_CYC
)
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   // Pins from processor, supply and comparators (asynchronous)
   input  wire logic        enable_i,
   input  wire logic        supply_ok_i,
   input  wire logic [7:0]  voltage_code_i,
   input  wire logic        low_power_request_n_i,
   input  wire logic        light_load_phase_select_i,
   input  wire logic        out_above_window_i,
   input  wire logic        out_below_window_i,
   input  wire logic        crowbar_release_i,
   input  wire logic        thermistor_low_i,
   // Same-clock inputs from modulator and soft-start
   input  wire logic [5:0]  pwm_i,
   input  wire logic        soft_start_done_i,
   // Outputs to drivers and system
   output logic [5:0]       pwm_o,
   output logic             soft_start_run_o,
   output logic             shed_phase_disable_n_o,
   output logic             core_phase_disable_n_o,
   output logic             output_good_flag_o,
   output logic             output_good_flag_oe_n_o,
   output logic             overtemp_flag_o
);

   // ---------------------------------------------------------------
   // Decoding functions
   // ---------------------------------------------------------------
   function automatic logic is_off_code(input logic [7:0] c);
      return (c == vr_supervisor_pkg::CODE_OFF_A) || (c == vr_supervisor_pkg::CODE_OFF_B)
          || (c == vr_supervisor_pkg::CODE_OFF_C) || (c == vr_supervisor_pkg::CODE_OFF_D);
   endfunction

   // Phases kept alive in the low-power state
   function automatic logic [5:0] keep_mask(input logic [2:0] n, input logic sel);
      if (!sel || (n < 3'h4))
         return vr_supervisor_pkg::KEEP_P1;
      else if (n == 3'h4)
         return vr_supervisor_pkg::KEEP_P13;
      else
         return vr_supervisor_pkg::KEEP_P14;
   endfunction

   function automatic logic [5:0] count_mask(input logic [2:0] n);
      logic [5:0] m;
      m = '0;
      for (int i = 0; i < vr_supervisor_pkg::PHASES; i++)
         m[i] = (3'(i) < n);
      return m;
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   sync_bus_if #(.W(16)) pins ();

   assign pins.raw = {voltage_code_i, enable_i, supply_ok_i, low_power_request_n_i,
                      light_load_phase_select_i, out_above_window_i, out_below_window_i,
                      crowbar_release_i, thermistor_low_i};

   pin_sync u_pin_sync
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .pins      (pins.sink)
   );

   // Comparator results only used after two stages
   wire logic [7:0] code_s    = pins.sync[15:8];
   wire logic       enable_s  = pins.sync[7];
   wire logic       supply_s  = pins.sync[6];
   wire logic       lp_n_s    = pins.sync[5];
   wire logic       sel_s     = pins.sync[4];
   wire logic       above_s   = pins.sync[3];
   wire logic       below_s   = pins.sync[2];
   wire logic       release_s = pins.sync[1];
   wire logic       therm_s   = pins.sync[0];

   // ---------------------------------------------------------------
   // Voltage code deskew and latch
   // ---------------------------------------------------------------
   logic [7:0]                         code_seen_q;
   logic [7:0]                         code_q;
   logic [vr_supervisor_pkg::CNT_W-1:0] settle_q;

   wire logic code_moved  = (code_s != code_seen_q);
   wire logic code_change = (settle_q == '0) && !code_moved && (code_q != code_seen_q);
   wire logic code_off    = is_off_code(code_q);

   // Bits that move restart the deskew wait, so skew never latches a code
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         code_seen_q <= vr_supervisor_pkg::CODE_RST;
         code_q      <= vr_supervisor_pkg::CODE_RST;
         settle_q    <= '0;
      end
      else
      begin
         code_seen_q <= code_s;
         if (code_moved)
            settle_q <= vr_supervisor_pkg::CNT_W'(vr_supervisor_pkg::SETTLE_CYC);
         else if (settle_q != '0)
            settle_q <= settle_q - 1'b1;
         if (code_change)
            code_q <= code_seen_q;
      end
   end

   // ---------------------------------------------------------------
   // Off-code confirmation and blanking timers
   // ---------------------------------------------------------------
   // Terminal counts cut to the counter width once, ahead of every use
   localparam logic [vr_supervisor_pkg::CNT_W-1:0] CNT_W_BLANK   =
      vr_supervisor_pkg::CNT_W'(BLANK_CYC);
   localparam logic [vr_supervisor_pkg::CNT_W-1:0] CNT_W_TURN    =
      vr_supervisor_pkg::CNT_W'(TURN_ON_CYC);
   localparam logic [vr_supervisor_pkg::CNT_W-1:0] CNT_W_CONFIRM =
      vr_supervisor_pkg::CNT_W'(vr_supervisor_pkg::CONFIRM_CYC);

   logic [vr_supervisor_pkg::CNT_W-1:0] off_cnt_q;
   logic [vr_supervisor_pkg::CNT_W-1:0] blank_q;

   wire logic off_confirmed = (off_cnt_q == CNT_W_CONFIRM);
   wire logic blank         = (blank_q != '0);

   // Each new code reloads the blanking window, so it ends after the last one
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         off_cnt_q <= '0;
         blank_q   <= '0;
      end
      else
      begin
         if (!code_off)
            off_cnt_q <= '0;
         else if (!off_confirmed)
            off_cnt_q <= off_cnt_q + 1'b1;
         if (code_change)
            blank_q <= CNT_W_BLANK;
         else if (blank)
            blank_q <= blank_q - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Start-up sequencer
   // ---------------------------------------------------------------
   vr_supervisor_pkg::run_state_type   state_q;
   vr_supervisor_pkg::run_state_type   state_d;
   logic [vr_supervisor_pkg::CNT_W-1:0] delay_q;

   wire logic run_ok    = enable_s && supply_s && !off_confirmed;
   wire logic switching = run_ok && (state_q != vr_supervisor_pkg::ST_OFF);
   wire logic delay_end = (delay_q == CNT_W_TURN);

   // Losing enable or supply drops straight back to off from any state
   always_comb
   begin
      state_d = state_q;
      if (!run_ok)
         state_d = vr_supervisor_pkg::ST_OFF;
      else
         case (state_q)
            vr_supervisor_pkg::ST_OFF:   state_d = vr_supervisor_pkg::ST_SOFT;
            vr_supervisor_pkg::ST_SOFT:
               if (soft_start_done_i)
                  state_d = vr_supervisor_pkg::ST_DELAY;
            vr_supervisor_pkg::ST_DELAY:
               if (delay_end)
                  state_d = vr_supervisor_pkg::ST_RUN;
            default:                     state_d = state_q;
         endcase
   end

   // Turn-on delay only counts once soft-start has arrived
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= vr_supervisor_pkg::ST_OFF;
         delay_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         if (state_q != vr_supervisor_pkg::ST_DELAY)
            delay_q <= '0;
         else if (!delay_end)
            delay_q <= delay_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Output-good, crowbar and over-temperature
   // ---------------------------------------------------------------
   logic good_q;
   logic crowbar_q;
   logic hot_q;

   // Comparators sit at +WIN_ABOVE_MV / -WIN_BELOW_MV around the code voltage
   wire logic in_window  = !above_s && !below_s;
   wire logic good_d     = (state_q == vr_supervisor_pkg::ST_RUN) && run_ok && !code_off
                           && (blank ? good_q : in_window);
   // Trip uses the window's upper comparator; a trip beats a release
   wire logic crowbar_d  = (above_s && !blank) || (crowbar_q && !release_s);

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         good_q    <= 1'b0;
         crowbar_q <= 1'b0;
         hot_q     <= 1'b0;
      end
      else
      begin
         good_q    <= good_d;
         crowbar_q <= crowbar_d;
         hot_q     <= therm_s;
      end
   end

   // ---------------------------------------------------------------
   // Phase gating and driver disables
   // ---------------------------------------------------------------
   logic [2:0] count_q;
   logic [5:0] pwm_q;
   logic       shed_n_q;
   logic       core_n_q;

   wire logic       low_power = !lp_n_s;
   wire logic [5:0] keep      = keep_mask(count_q, sel_s);
   wire logic [5:0] lp_mask   = low_power ? keep : 6'h3F;
   wire logic [5:0] pwm_d     = pwm_i & count_mask(count_q) & lp_mask
                                & {6{switching && !crowbar_q}};

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         pwm_q    <= '0;
         shed_n_q <= 1'b0;
         core_n_q <= 1'b0;
      end
      else
      begin
         pwm_q    <= pwm_d;
         shed_n_q <= switching && !low_power;
         core_n_q <= switching;
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ---------------------------------------------------------------
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [31:0] rdata_q;

   wire logic       take    = hsel_i && hready_i && htrans_i[1];
   wire logic       cfg_wr  = wr_pend_q && (wr_addr_q == vr_supervisor_pkg::CFG_ADDR);
   wire logic [2:0] count_d = cfg_wr ? hwdata_i[vr_supervisor_pkg::CFG_COUNT_LSB +: 3] : count_q;
   wire logic [31:0] status_word = {16'h0000, code_q, state_q, hot_q, crowbar_q, blank,
                                    low_power, good_q, switching};
   // Reads see a write landing in the same edge, so back-to-back is coherent
   wire logic [31:0] rdata_d =
      (haddr_i[7:0] == vr_supervisor_pkg::CFG_ADDR)    ? {29'h0, count_d} :
      (haddr_i[7:0] == vr_supervisor_pkg::STATUS_ADDR) ? status_word : 32'h0000_0000;

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         rdata_q   <= '0;
         count_q   <= vr_supervisor_pkg::CFG_RST;
      end
      else
      begin
         wr_pend_q <= take && hwrite_i;
         wr_addr_q <= haddr_i[7:0];
         count_q   <= count_d;
         if (take && !hwrite_i)
            rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Output assignments
   // ---------------------------------------------------------------
   assign hreadyout_o             = 1'b1;
   assign hresp_o                 = 1'b0;
   assign hrdata_o                = rdata_q;
   assign pwm_o                   = pwm_q;
   assign soft_start_run_o        = (state_q != vr_supervisor_pkg::ST_OFF);
   assign shed_phase_disable_n_o  = shed_n_q;
   assign core_phase_disable_n_o  = core_n_q;
   assign output_good_flag_o      = 1'b0;
   assign output_good_flag_oe_n_o = good_q; // Open drain: pull low unless good
   assign overtemp_flag_o         = hot_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_code_step;
      code_change ##1 blank;
   endsequence

   chk_good_gated: assert property (!run_ok || code_off |=> !good_q)
      else $error("output-good high while disabled or no-processor code");
   chk_good_run_only: assert property ($rose(good_q) |->
                                       $past(state_q) == vr_supervisor_pkg::ST_RUN)
      else $error("output-good rose before turn-on delay ended");
   chk_blank_hold: assert property (s_code_step |-> $stable(good_q) || !good_q)
      else $error("output-good rose during blanking");
   chk_blank_reload: assert property (code_change |=> blank_q == CNT_W_BLANK)
      else $error("blanking not restarted by code change");
   chk_code_deskew: assert property (code_moved |=> $stable(code_q) [*8])
      else $error("code latched during deskew");
   chk_crowbar_pwm: assert property (above_s && !blank |=> ##1 pwm_o == 6'h00)
      else $error("PWM not forced low by crowbar");
   chk_disabled_out: assert property (!switching |=>
                                      !core_n_q && !shed_n_q && pwm_o == 6'h00)
      else $error("outputs active while disabled");
   chk_shed_low: assert property (low_power |=> !shed_phase_disable_n_o)
      else $error("shed disable not low in low power");
   chk_phase1_only: assert property (low_power && !sel_s |=> pwm_o[5:1] == 5'h00)
      else $error("extra phase active in low power");
   chk_four_phase: assert property (low_power && sel_s && count_q == 3'h4
                                    |=> (pwm_o & ~vr_supervisor_pkg::KEEP_P13) == 6'h00)
      else $error("wrong kept phases in four-phase low power");
   chk_overtemp: assert property (therm_s |=> overtemp_flag_o)
      else $error("over-temperature flag not raised");
   chk_start_gate: assert property ($changed(state_q)
                                    && state_q != vr_supervisor_pkg::ST_OFF |-> $past(run_ok))
      else $error("sequencer advanced without enable and supply");
   chk_off_confirm: assert property ($rose(off_confirmed) |->
                                     $past(code_off) && $past(off_cnt_q) != '0)
      else $error("shutdown without confirmed off code");

endmodule // vr_supervisor_phase_control
`default_nettype wire

/* File: shared/vr_supervisor_pkg.sv */
// Constants and timing for the regulator supervisory and phase-control block
package vr_supervisor_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ          = 250;
   localparam int BLANK_NS         = 100000;
   localparam int SETTLE_NS        = 200;
   localparam int CONFIRM_NS       = 5000;
   localparam int TURN_ON_NS       = 1000000;
   localparam int CNT_W            = 20;
   // Least times round up to whole cycles
   localparam int BLANK_CYC        = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC       = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CONFIRM_CYC      = (CONFIRM_NS * CLK_MHZ + 999) / 1000;
   localparam int TURN_ON_CYC      = (TURN_ON_NS * CLK_MHZ + 999) / 1000;

   // ---------------------------------------------------------------
   // Analog thresholds the comparators are built around
   // ---------------------------------------------------------------
   localparam int WIN_ABOVE_MV     = 300;
   localparam int WIN_BELOW_MV     = 500;
   localparam int RELEASE_MV       = 300;
   localparam int HOT_THRESH_MV    = 810;

   // ---------------------------------------------------------------
   // Phases and codes
   // ---------------------------------------------------------------
   localparam int PHASES           = 6;
   localparam logic [7:0] CODE_OFF_A = 8'h00;
   localparam logic [7:0] CODE_OFF_B = 8'h01;
   localparam logic [7:0] CODE_OFF_C = 8'hFE;
   localparam logic [7:0] CODE_OFF_D = 8'hFF;
   localparam logic [7:0] CODE_RST   = 8'h00;
   localparam logic [5:0] KEEP_P1    = 6'h01;
   localparam logic [5:0] KEEP_P13   = 6'h05;
   localparam logic [5:0] KEEP_P14   = 6'h09;

   // ---------------------------------------------------------------
   // Register map (byte addresses) and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CFG_ADDR    = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [2:0] CFG_RST     = 3'h6;
   localparam int CFG_COUNT_LSB       = 0;
   localparam int ST_CODE_LSB         = 8;

   // ---------------------------------------------------------------
   // Supervisor states, Gray coded along the start-up path
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_OFF   = 2'b00,
      ST_SOFT  = 2'b01,
      ST_DELAY = 2'b11,
      ST_RUN   = 2'b10
   } run_state_type;

endpackage : vr_supervisor_pkg

/* File: shared/sync_bus_if.sv */
// Carrier between asynchronous pin inputs and their synchroniser
`timescale 1ns/1ns
`default_nettype none
interface sync_bus_if #(parameter int W = 16);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport src  (output raw, input sync);
   modport sink (input raw, output sync);
endinterface : sync_bus_if
`default_nettype wire

/* File: core/pin_sync.sv */
// Two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync
(
   // Clock and reset
   input  wire logic     sys_clk_i,
   input  wire logic     reset_i,
   // Raw and synchronised bundle
   sync_bus_if.sink      pins
);
   localparam int W = $bits(pins.raw);

   // ---------------------------------------------------------------
   // Stages
   // ---------------------------------------------------------------
   logic [W-1:0] meta_q;
   logic [W-1:0] stable_q;

   // First stage feeds only the second
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_q   <= '0;
         stable_q <= '0;
      end
      else
      begin
         meta_q   <= pins.raw;
         stable_q <= meta_q;
      end
   end

   assign pins.sync = stable_q;
endmodule // pin_sync
`default_nettype wire

/* File: sim/gate_driver_model.sv */
// Behavioural model of one external MOSFET gate driver stage
`timescale 1ns/1ns
`default_nettype none
module gate_driver_model
(
   // Controller side
   input  wire logic pwm_i,
   input  wire logic disable_n_i,
   // Gate drives
   output logic      high_gate_o,
   output logic      low_gate_o
);
   // ---------------------------------------------------------------
   // Gate steering
   // ---------------------------------------------------------------
   // Disable wins over PWM so a shed phase never pulls the output
   assign high_gate_o = disable_n_i & pwm_i;
   assign low_gate_o  = disable_n_i & ~pwm_i;
endmodule // gate_driver_model
`default_nettype wire

/* File: sim/test_vr_supervisor_phase_control.sv */
// Self-checking bench for the supervisory and phase-control block
`timescale 1ns/1ns
`default_nettype none
module test_vr_supervisor_phase_control;
   // ---------------------------------------------------------------
   // Stimulus, observation and board wiring
   // ---------------------------------------------------------------
   // Longer than the code deskew so a second code can land inside a blank
   localparam int BLANK = 100;
   localparam int TON   = 30;
   logic        sys_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [31:0] haddr   = 32'h0, hwdata = 32'h0, rd;
   logic        en = 1'b0, sup = 1'b0, lp_n = 1'b1, strap = 1'b0, above = 1'b0;
   logic        below = 1'b0, rel = 1'b0, therm = 1'b0, ss_done = 1'b0;
   logic [7:0]  code    = 8'h02;
   logic [5:0]  pwm_in  = 6'h3F;
   logic [31:0] hrdata;
   logic [5:0]  pwm_out, hi_g, lo_g, keep;
   logic        hreadyout, hresp, ss_run, shed_n, core_n, good_o, good_oe_n, hot;
   wire         good_wire;
   int          n_fail = 0, n_compared = 0, k;
   logic [2:0]  cnt[6] = '{3'h6, 3'h6, 3'h5, 3'h4, 3'h3, 3'h1};
   logic        st[6]  = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
   logic [5:0]  ex[6]  = '{6'h01, 6'h09, 6'h09, 6'h05, 6'h01, 6'h01};

   // Open-drain flag with a board pull-up
   assign good_wire = good_oe_n ? 1'b1 : good_o;
   // Board routing follows the strap: kept phases on the core disable
   assign keep = strap ? 6'h09 : 6'h01;

   always #2 sys_clk = ~sys_clk;

   vr_supervisor_phase_control #(.BLANK_CYC(BLANK), .TURN_ON_CYC(TON)) dut_u
   (
      .sys_clk_i(sys_clk), .reset_i(reset), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .hrdata_o(hrdata), .enable_i(en), .supply_ok_i(sup), .voltage_code_i(code),
      .low_power_request_n_i(lp_n), .light_load_phase_select_i(strap),
      .out_above_window_i(above), .out_below_window_i(below),
      .crowbar_release_i(rel), .thermistor_low_i(therm), .pwm_i(pwm_in),
      .soft_start_done_i(ss_done), .pwm_o(pwm_out), .soft_start_run_o(ss_run),
      .shed_phase_disable_n_o(shed_n), .core_phase_disable_n_o(core_n),
      .output_good_flag_o(good_o), .output_good_flag_oe_n_o(good_oe_n),
      .overtemp_flag_o(hot)
   );

   // Six driver stages, each fed by one PWM line and one disable
   for (genvar g = 0; g < 6; g++)
   begin : drv_g
      gate_driver_model drv_u
      (
         .pwm_i(pwm_out[g]), .disable_n_i(keep[g] ? core_n : shed_n),
         .high_gate_o(hi_g[g]), .low_gate_o(lo_g[g])
      );
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Outputs are compared mid-cycle, well clear of the launching edge
   task look;
      @(negedge sys_clk);
   endtask

   // One single-word transfer; only the watchdog ends a wait
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task end_sim;
      $display("compared=%0d mismatches=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial
   begin
      cyc(2);
      reset <= 1'b0;
      ahb(1'b0, vr_supervisor_pkg::CFG_ADDR, 32'h0);
      cmp(rd, {29'h0, vr_supervisor_pkg::CFG_RST});
      cmp({hreadyout, hresp}, 32'h2);
      ahb(1'b0, 8'h08, 32'h0);
      cmp(rd, 32'h0);
      ahb(1'b1, vr_supervisor_pkg::CFG_ADDR, 32'h4);
      ahb(1'b0, vr_supervisor_pkg::CFG_ADDR, 32'h0);
      cmp(rd, 32'h4);
      look;
      cmp({ss_run, pwm_out, shed_n, core_n, good_wire}, 32'h0);
      $display("registers and idle state done");
      cyc(1);
      en <= 1'b1;
      sup <= 1'b1;
      for (k = 0; k < 300 && ss_run !== 1'b1; k++) cyc(1);
      cyc(100);
      look;
      cmp({ss_run, good_wire}, 32'h2);
      cyc(1);
      ss_done <= 1'b1;
      for (k = 0; k < 500 && good_oe_n !== 1'b1; k++) cyc(1);
      cmp(k >= TON && k < 500, 1'b1);
      look;
      cmp({good_wire, pwm_out}, 32'h4F);
      ahb(1'b0, vr_supervisor_pkg::STATUS_ADDR, 32'h0);
      cmp(rd, {16'h0, 8'h02, vr_supervisor_pkg::ST_RUN, 6'h03});
      $display("start-up done");
      for (int i = 0; i < 6; i++)
      begin
         ahb(1'b1, vr_supervisor_pkg::CFG_ADDR, {29'h0, cnt[i]});
         strap <= st[i];
         lp_n <= 1'b0;
         cyc(8);
         look;
         cmp({pwm_out, shed_n, core_n}, {ex[i], 2'b01});
         if (i == 1) cmp(hi_g, 6'h09);
      end
      ahb(1'b1, vr_supervisor_pkg::CFG_ADDR, 32'h6);
      lp_n <= 1'b1;
      cyc(8);
      look;
      cmp({pwm_out, shed_n}, 32'h7F);
      $display("phase shedding done");
      cyc(1);
      above <= 1'b1;
      cyc(6);
      look;
      cmp({pwm_out, good_wire}, 32'h0);
      cyc(1);
      above <= 1'b0;
      cyc(6);
      look;
      cmp(pwm_out, 32'h0);
      cyc(1);
      rel <= 1'b1;
      cyc(6);
      look;
      cmp(pwm_out, 32'h3F);
      cyc(1);
      rel <= 1'b0;
      $display("crowbar done");
      code <= 8'h03;
      cyc(58);
      // Second code latches inside the first blank and must restart it
      below <= 1'b1;
      code <= 8'h04;
      cyc(5);
      look;
      cmp(good_wire, 1'b1);
      cyc(BLANK);
      look;
      cmp(good_wire, 1'b1);
      cyc(52);
      look;
      cmp(good_wire, 1'b0);
      cyc(1);
      below <= 1'b0;
      therm <= 1'b1;
      cyc(5);
      look;
      cmp(hot, 1'b1);
      cyc(1);
      therm <= 1'b0;
      cyc(5);
      look;
      cmp(hot, 1'b0);
      $display("blanking and temperature done");
      cyc(1);
      code <= 8'hFE;
      cyc(1200);
      look;
      cmp({ss_run, good_wire}, 32'h2);
      cyc(150);
      look;
      cmp({ss_run, pwm_out}, 32'h0);
      cyc(1);
      code <= 8'h02;
      for (k = 0; k < 800 && good_oe_n !== 1'b1; k++) cyc(1);
      en <= 1'b0;
      cyc(6);
      look;
      cmp({pwm_out, shed_n, core_n, good_wire}, 32'h0);
      $display("off code and disable done");
      end_sim;
   end

   // Whole run is near 2000 cycles; this bound only cuts a hang
   initial
   begin
      #60000;
      n_fail++;
      end_sim;
   end
endmodule // test_vr_supervisor_phase_control
`default_nettype wire
